// >>> design/pcrs_top.sv
// What this block does
// - Keep 21-bit byte program counter, 2-Mbyte space.
// - Fetch beyond implemented memory returns zero.
// - Reset to 0000h; interrupts vector 0008h/0018h.
// - Only low byte writable; upper via latches; whole counter readable.
// - Low byte write loads latches into counter.
// - Low byte read copies upper bytes to latches.
// - Bit zero fixed; advance by two.
// - Calls, gotos, branches load directly, skip latches.
// - Push on call/interrupt, pop on returns.
// - Stack is 31 by 21 bits, 5-bit pointer.
// - Push increments then writes; pop reads then decrements.
// - Reset zeroes pointer; zero means empty.
// - Three top-entry bytes access selected entry.
// - Software reads and writes pointer, zero to 31.
// - Error reset: 31st push stores, flags, resets.
// - No error reset: pointer stops at 31.
// - Empty pop loads zero, flags underflow.
// - Flags always set; reset only if enabled.
// - Status: full bit7, underflow bit6, pointer low.
// - Flags software clearable only, else power-on.
// - Software push stores counter; pop only decrements.
// - Interrupt loads shadow; fast return restores it.
// - Fast call saves shadow; fast return restores.
// - Counter acts on first quarter phase.
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pcrs_top (
	input  wire logic                     CLOCK_IN,           // Core clock, 40 MHz
	input  wire logic                     RST_N_IN,           // Any device reset, sync, low
	input  wire logic                     POR_N_IN,           // Power-on reset, sync, low
	input  wire pcrs_pkg::pcrs_cmd_type   CMD_IN,             // Decoder command
	input  wire pcrs_pkg::pcrs_shadow_type SHADOW_IN,         // Live status, working, bank
	input  wire logic [15:0]              FETCH_DATA_IN,      // Program memory word
	input  wire logic                     WB_CYC_IN,          // Wishbone cycle
	input  wire logic                     WB_STB_IN,          // Wishbone strobe
	input  wire logic                     WB_WE_IN,           // Wishbone write enable
	input  wire logic [7:0]               WB_ADR_IN,          // Wishbone byte address
	input  wire logic [3:0]               WB_SEL_IN,          // Wishbone byte enables
	input  wire logic [31:0]              WB_DAT_IN,          // Wishbone write data
	output logic [31:0]                   WB_DAT_OUT,         // Wishbone read data
	output logic                          WB_ACK_OUT,         // Wishbone acknowledge
	output logic [20:0]                   PC_OUT,             // Fetch address
	output logic [15:0]                   INSTR_OUT,          // Fetched word, zero if absent
	output logic                          FIRST_QUARTER_OUT,  // First quarter phase marker
	output logic                          CMD_ACK_OUT,        // Command taken pulse
	output logic                          STACK_RESET_OUT,    // Stack error reset request
	output pcrs_pkg::pcrs_shadow_type     SHADOW_OUT,         // Shadow contents
	output logic                          SHADOW_RESTORE_OUT  // Restore shadow pulse
);
	import pcrs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	logic [1:0]      phase_reg;          // Quarter phase counter
	logic            q1_reg;             // High during first_quarter_phase

	// Counter and latches
	logic [PC_W-1:0] pc_reg;             // Program counter
	logic [PC_W-1:0] pc_next;            // Next program counter
	logic [7:0]      lath_reg;           // pc_high_holding_latch
	logic [7:0]      lath_next;          // Next high latch
	logic [4:0]      latu_reg;           // pc_upper_holding_latch
	logic [4:0]      latu_next;          // Next upper latch

	// Pointer, flags, option
	logic [SP_W-1:0] sp_reg;             // pointer_value
	logic [SP_W-1:0] sp_next;            // Next pointer
	logic            full_reg;           // stack_full_flag
	logic            unf_reg;            // stack_underflow_flag
	logic            cfg_reg;            // stack_error_reset_enable
	logic            cfg_next;           // Next enable

	// Flag strobes
	logic            full_set;           // Hardware sets full
	logic            full_clr;           // Software clears full
	logic            unf_set;            // Hardware sets underflow
	logic            unf_clr;            // Software clears underflow

	// One cycle requests
	logic            err_next;           // Stack error reset request
	logic            restore_next;       // Shadow restore request

	// Shadow and stack
	logic            shadow_load;        // Shadow capture enable
	pcrs_shadow_type shadow_reg;         // One-level shadow
	logic [PC_W-1:0] stack_mem [1:31];   // Return stack storage
	logic            mem_we;             // Stack write strobe
	logic [SP_W-1:0] mem_addr;           // Stack write index
	logic [PC_W-1:0] mem_wdata;          // Stack write data

	// Bus and pulses
	logic            ack_reg;            // Bus acknowledge
	logic [31:0]     rdata_reg;          // Bus read data
	logic [31:0]     rdata_next;         // Bus read mux
	logic            cmd_ack_reg;        // Command taken
	logic [15:0]     instr_reg;          // Fetched word
	logic            err_reg;            // Error reset pulse
	logic            restore_reg;        // Restore pulse

	////////////////////////////////////////////////////////////////////////
	// Decode wires
	wire logic            first_quarter_phase = q1_reg;                       // Command slot
	wire logic            cmd_take  = first_quarter_phase && (CMD_IN.op != OP_NONE);
	// Bus is kept out of the command slot so the two never fight over the stack port
	wire logic            bus_req   = WB_CYC_IN && WB_STB_IN && !ack_reg && !first_quarter_phase;
	wire logic            bus_wr    = bus_req && WB_WE_IN && WB_SEL_IN[0];    // Low lane write
	wire logic            bus_rd    = bus_req && !WB_WE_IN;                   // Read access

	// Register selects
	wire logic            sel_stat  = (WB_ADR_IN == OFS_STATUS);              // Status select
	wire logic            sel_pcl   = (WB_ADR_IN == OFS_PC_LOW);              // Low byte select
	wire logic            sel_lath  = (WB_ADR_IN == OFS_LATH);                // High latch select
	wire logic            sel_latu  = (WB_ADR_IN == OFS_LATU);                // Upper latch select
	wire logic            sel_tl    = (WB_ADR_IN == OFS_TOP_LOW);             // Top low select
	wire logic            sel_th    = (WB_ADR_IN == OFS_TOP_HIGH);            // Top high select
	wire logic            sel_tu    = (WB_ADR_IN == OFS_TOP_UP);              // Top upper select
	wire logic            sel_cfg   = (WB_ADR_IN == OFS_CONFIG);              // Config select
	wire logic            sel_pcf   = (WB_ADR_IN == OFS_PC_FULL);             // Whole counter

	// Pointer math wraps at 5 bits
	wire logic            sp_empty  = (sp_reg == SP_RESET_VAL);
	wire logic            sp_full   = (sp_reg == SP_MAX);
	wire logic [SP_W-1:0] sp_inc    = sp_reg + SP_ONE;                        // Pointer plus one
	wire logic [SP_W-1:0] sp_dec    = sp_reg - SP_ONE;                        // Pointer minus one
	wire logic [PC_W-1:0] top_entry = sp_empty ? '0 : stack_mem[sp_reg];

	// Counter math
	wire logic [PC_W-1:0] pc_inc    = pc_reg + PC_STEP;
	wire logic [PC_W-1:0] vector    = CMD_IN.vec_high ? VEC_HIGH : VEC_LOW;
	// Word is for the live counter; INSTR_OUT lags a clock
	wire logic            in_memory = (pc_reg < PROG_BYTES);
	wire logic [7:0]      wbyte     = WB_DAT_IN[7:0];                         // Written byte
	wire logic [7:0]      status_byte = {full_reg, unf_reg, 1'b0, sp_reg};

	////////////////////////////////////////////////////////////////////////
	// Read data mux, reserved bits and unmapped offsets read zero
	always_comb begin
		// Unselected lanes read zero
		rdata_next = 32'h00000000;
		if (sel_stat) begin
			rdata_next[7:0] = status_byte;
		end else if (sel_pcl) begin
			rdata_next[7:0] = pc_reg[7:0];
		end else if (sel_lath) begin
			rdata_next[7:0] = lath_reg;                    // Latch readback
		end else if (sel_latu) begin
			rdata_next[4:0] = latu_reg;                    // Latch readback
		end else if (sel_tl) begin
			rdata_next[7:0] = top_entry[7:0];
		end else if (sel_th) begin
			rdata_next[7:0] = top_entry[15:8];
		end else if (sel_tu) begin
			rdata_next[4:0] = top_entry[20:16];
		end else if (sel_cfg) begin
			rdata_next[0] = cfg_reg;                       // Enable readback
		end else if (sel_pcf) begin
			rdata_next[PC_W-1:0] = pc_reg;                 // Whole counter
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state for counter, pointer, flags and stack port
	always_comb begin
		pc_next      = pc_reg;
		lath_next    = lath_reg;
		latu_next    = latu_reg;
		sp_next      = sp_reg;
		cfg_next     = cfg_reg;
		full_set     = 1'b0;
		full_clr     = 1'b0;
		unf_set      = 1'b0;
		unf_clr      = 1'b0;
		err_next     = 1'b0;
		restore_next = 1'b0;
		shadow_load  = 1'b0;

		// Stack port idles
		mem_we       = 1'b0;
		mem_addr     = sp_reg;
		mem_wdata    = pc_reg;
		if (cmd_take) begin
			case (CMD_IN.op)
				// Sequential fetch
				OP_STEP: begin
					pc_next = pc_inc;
				end
				// Direct load, holding latches untouched
				OP_JUMP: begin
					pc_next = {CMD_IN.target[20:1], 1'b0};
				end
				// Every push flavour shares the overflow handling
				OP_CALL, OP_INT, OP_PUSH: begin
					if (!sp_full) begin
						mem_we    = 1'b1;
						mem_addr  = sp_inc;
						mem_wdata = pc_reg;
						sp_next   = sp_inc;
						if (sp_inc == SP_MAX) begin
							full_set = 1'b1;
							if (cfg_reg) begin
								sp_next  = SP_RESET_VAL;
								err_next = 1'b1;
							end
						end
					end else begin
						full_set = 1'b1;
					end

					// Destination per flavour
					if (CMD_IN.op == OP_CALL) begin
						pc_next     = {CMD_IN.target[20:1], 1'b0};
						shadow_load = CMD_IN.fast;
					end else if (CMD_IN.op == OP_INT) begin
						pc_next     = vector;
						shadow_load = 1'b1;
					end
				end
				// Return flavours pull the counter back
				OP_RETURN: begin
					restore_next = CMD_IN.fast;
					if (sp_empty) begin
						pc_next  = PC_RESET_VAL;
						unf_set  = 1'b1;
						err_next = cfg_reg;
					end else begin
						pc_next = {top_entry[20:1], 1'b0};
						sp_next = sp_dec;
					end
				end
				// Software pop only drops the top entry
				OP_POP: begin
					if (sp_empty) begin
						unf_set  = 1'b1;
						err_next = cfg_reg;
					end else begin
						sp_next = sp_dec;
					end
				end
				default: begin
				end
			endcase
		end else if (bus_wr) begin
			// Software writes, slot excluded
			if (sel_stat) begin
				sp_next  = wbyte[4:0];
				full_clr = !wbyte[FULL_BIT];
				unf_clr  = !wbyte[UNF_BIT];
			end else if (sel_pcl) begin
				pc_next = {latu_reg, lath_reg, wbyte[7:1], 1'b0};
			end else if (sel_lath) begin
				lath_next = wbyte;
			end else if (sel_latu) begin
				latu_next = wbyte[4:0];
			end else if (sel_cfg) begin
				cfg_next = wbyte[0];                               // Option bit
			end else if (!sp_empty && (sel_tl || sel_th || sel_tu)) begin
				mem_we    = 1'b1;
				mem_wdata = top_entry;
				if (sel_tl) begin
					mem_wdata[7:0] = wbyte;
				end else if (sel_th) begin
					mem_wdata[15:8] = wbyte;
				end else begin
					mem_wdata[20:16] = wbyte[4:0];
				end
			end
		end else if (bus_rd && sel_pcl) begin
			// Snapshot upper bytes
			lath_next = pc_reg[15:8];
			latu_next = pc_reg[20:16];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Quarter phase divider, clock divided by four
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || !POR_N_IN) begin
			phase_reg <= 2'h0;
			q1_reg    <= 1'b1;
		end else begin
			// Slot rises as count wraps
			phase_reg <= phase_reg + 2'h1;
			q1_reg    <= (phase_reg == 2'h3);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter, latches and pointer follow every device reset
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || !POR_N_IN) begin
			pc_reg   <= PC_RESET_VAL;
			lath_reg <= 8'h00;
			latu_reg <= 5'h00;
			sp_reg   <= SP_RESET_VAL;
		end else begin
			pc_reg   <= pc_next;
			lath_reg <= lath_next;
			latu_reg <= latu_next;
			sp_reg   <= sp_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flags and option survive all but power-on; set beats clear
	always_ff @(posedge CLOCK_IN) begin
		if (!POR_N_IN) begin
			full_reg <= 1'b0;
			unf_reg  <= 1'b0;
			cfg_reg  <= ERR_RST_RESET_VAL;
		end else begin
			// Set beats a same-cycle clear
			full_reg <= full_set || (full_reg && !full_clr);
			unf_reg  <= unf_set || (unf_reg && !unf_clr);
			cfg_reg  <= cfg_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stack storage, no reset so it maps onto plain RAM
	always_ff @(posedge CLOCK_IN) begin
		// Index zero has no storage
		if (mem_we && (mem_addr != SP_RESET_VAL)) begin
			stack_mem[mem_addr] <= mem_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shadow registers, contents undefined until first capture
	always_ff @(posedge CLOCK_IN) begin
		if (shadow_load) begin
			shadow_reg <= SHADOW_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus answer, fetch word and pulses
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || !POR_N_IN) begin
			ack_reg     <= 1'b0;
			rdata_reg   <= 32'h00000000;
			cmd_ack_reg <= 1'b0;
			instr_reg   <= 16'h0000;
			err_reg     <= 1'b0;
			restore_reg <= 1'b0;
		end else begin
			// Ack falls as bus_req needs it low
			ack_reg     <= bus_req;
			rdata_reg   <= bus_rd ? rdata_next : 32'h00000000;
			cmd_ack_reg <= cmd_take;
			instr_reg   <= in_memory ? FETCH_DATA_IN : 16'h0000;
			err_reg     <= err_next;
			restore_reg <= restore_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	// All pins come from flops
	assign WB_ACK_OUT         = ack_reg;
	assign WB_DAT_OUT         = rdata_reg;
	assign PC_OUT             = pc_reg;
	assign INSTR_OUT          = instr_reg;
	assign FIRST_QUARTER_OUT  = q1_reg;
	assign CMD_ACK_OUT        = cmd_ack_reg;
	assign STACK_RESET_OUT    = err_reg;
	assign SHADOW_OUT         = shadow_reg;
	assign SHADOW_RESTORE_OUT = restore_reg;

endmodule

`default_nettype wire

// >>> design/pcrs_pkg.sv
// Shared constants and carriers for the program counter and return stack
package pcrs_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int PC_W       = 21;                  // Byte address width
	localparam int SP_W       = 5;                   // Stack pointer width
	localparam int INSTR_W    = 16;                  // Fetched instruction word
	localparam int ADR_W      = 8;                   // Wishbone byte address

	////////////////////////////////////////////////////////////////////////
	// Program counter constants
	localparam logic [PC_W-1:0] PC_RESET_VAL = 21'h000000; // Reset vector
	localparam logic [PC_W-1:0] VEC_HIGH     = 21'h000008; // High priority vector
	localparam logic [PC_W-1:0] VEC_LOW      = 21'h000018; // Low priority vector
	localparam logic [PC_W-1:0] PC_STEP      = 21'h000002; // Sequential advance
	localparam logic [PC_W-1:0] PROG_BYTES   = 21'h008000; // Implemented memory size

	////////////////////////////////////////////////////////////////////////
	// Stack constants
	localparam logic [SP_W-1:0] SP_RESET_VAL = 5'h00;  // Empty marker
	localparam logic [SP_W-1:0] SP_MAX       = 5'h1F;  // Last entry (31)
	localparam logic [SP_W-1:0] SP_ONE       = 5'h01;  // Pointer step
	localparam logic            ERR_RST_RESET_VAL = 1'b1; // Error reset on by default

	////////////////////////////////////////////////////////////////////////
	// Status byte field positions
	localparam int FULL_BIT = 7;                     // Full flag
	localparam int UNF_BIT  = 6;                     // Underflow flag

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [ADR_W-1:0] OFS_STATUS   = 8'h00; // stack_pointer_status
	localparam logic [ADR_W-1:0] OFS_PC_LOW   = 8'h04; // pc_low_byte
	localparam logic [ADR_W-1:0] OFS_LATH     = 8'h08; // pc_high_holding_latch
	localparam logic [ADR_W-1:0] OFS_LATU     = 8'h0C; // pc_upper_holding_latch
	localparam logic [ADR_W-1:0] OFS_TOP_LOW  = 8'h10; // top_entry_low
	localparam logic [ADR_W-1:0] OFS_TOP_HIGH = 8'h14; // top_entry_high
	localparam logic [ADR_W-1:0] OFS_TOP_UP   = 8'h18; // top_entry_upper
	localparam logic [ADR_W-1:0] OFS_CONFIG   = 8'h1C; // stack_error_reset_enable
	localparam logic [ADR_W-1:0] OFS_PC_FULL  = 8'h20; // Whole counter, read only

	////////////////////////////////////////////////////////////////////////
	// Core command set
	typedef enum logic [2:0] {
		OP_NONE,     // Idle
		OP_STEP,     // Sequential fetch advance
		OP_JUMP,     // Goto or branch
		OP_CALL,     // Call or relative call
		OP_RETURN,   // Return, return with literal, return from interrupt
		OP_INT,      // Interrupt acknowledge
		OP_PUSH,     // Software push
		OP_POP       // Software pop
	} pcrs_op_type;

	typedef struct packed {
		pcrs_op_type     op;        // Operation
		logic            fast;      // Fast variant uses the shadow
		logic            vec_high;  // Interrupt picks the high vector
		logic [PC_W-1:0] target;    // Destination from the instruction
	} pcrs_cmd_type;

	typedef struct packed {
		logic [7:0] status;         // Status register
		logic [7:0] working;        // working_register
		logic [7:0] bank;           // bank_select_register
	} pcrs_shadow_type;

endpackage

// >>> bench/pcrs_checker.sv
`timescale 1ns/1ps
`default_nettype none

module pcrs_checker
	import pcrs_pkg::*;
(
	input wire logic                      CLOCK_IN,           // Core clock
	input wire logic                      RST_N_IN,           // Device reset
	input wire logic                      POR_N_IN,           // Power-on reset
	input wire pcrs_pkg::pcrs_cmd_type    CMD_IN,             // Decoder command
	input wire pcrs_pkg::pcrs_shadow_type SHADOW_IN,          // Live shadow source
	input wire logic                      WB_CYC_IN,          // Bus cycle
	input wire logic [20:0]               PC_OUT,             // Counter
	input wire logic [15:0]               INSTR_OUT,          // Fetched word
	input wire logic                      FIRST_QUARTER_OUT,  // Command slot
	input wire logic                      STACK_RESET_OUT,    // Reset request
	input wire pcrs_pkg::pcrs_shadow_type SHADOW_OUT,         // Saved shadow
	input wire logic                      SHADOW_RESTORE_OUT  // Restore pulse
);
	default clocking dcb @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN || !POR_N_IN);

	////////////////////////////////////////////////////////////////////////
	// A command is only taken in the slot
	wire logic slot; // Command taken this edge
	assign slot = FIRST_QUARTER_OUT && (CMD_IN.op != OP_NONE);

	////////////////////////////////////////////////////////////////////////
	AST_PC_EVEN: assert property (PC_OUT[0] == 1'b0)
		else $error("counter bit zero set");
	AST_STEP: assert property (slot && CMD_IN.op == OP_STEP |=> PC_OUT == $past(PC_OUT) + PC_STEP)
		else $error("step did not add two");
	AST_JUMP: assert property (slot && CMD_IN.op == OP_JUMP |=> PC_OUT == ($past(CMD_IN.target) & ~21'h1))
		else $error("jump target not loaded");
	AST_VECTOR: assert property (slot && CMD_IN.op == OP_INT |=>
		PC_OUT == ($past(CMD_IN.vec_high) ? VEC_HIGH : VEC_LOW))
		else $error("wrong interrupt vector");
	AST_SHADOW_LOAD: assert property (slot && (CMD_IN.op == OP_INT || (CMD_IN.op == OP_CALL && CMD_IN.fast))
		|=> SHADOW_OUT == $past(SHADOW_IN))
		else $error("shadow not captured");
	AST_RESTORE: assert property (slot && CMD_IN.op == OP_RETURN |=> SHADOW_RESTORE_OUT == $past(CMD_IN.fast))
		else $error("restore pulse wrong");
	AST_QUARTER: assert property (FIRST_QUARTER_OUT |=> !FIRST_QUARTER_OUT [*3] ##1 FIRST_QUARTER_OUT)
		else $error("slot not one in four");
	AST_INSTR_VOID: assert property (PC_OUT >= PROG_BYTES |=> INSTR_OUT == 16'h0000)
		else $error("absent memory not blank");
	AST_PC_QUIET: assert property (!slot && !WB_CYC_IN |=> $stable(PC_OUT))
		else $error("counter moved outside slot");

	// Main scenarios reached
	COV_INT: cover property (slot && CMD_IN.op == OP_INT);
	COV_ERR: cover property (STACK_RESET_OUT);
	COV_FAST: cover property (SHADOW_RESTORE_OUT);
endmodule

`default_nettype wire

// >>> bench/pcrs_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module pcrs_core_model
	import pcrs_pkg::*;
(
	input  wire logic         clk_in,     // Core clock
	input  wire logic [20:0]  pc_in,      // Fetch address
	input  wire logic         q1_in,      // Command slot marker
	input  wire logic         go_in,      // Bench queues a command
	input  wire pcrs_cmd_type req_in,     // Queued command
	output var pcrs_cmd_type  cmd_out,    // Command level to the block
	output logic [15:0]       fetch_out   // Program memory word
);
	initial cmd_out = '0;

	// Hold a command until a slot takes it, then go idle
	always @(posedge clk_in) begin
		if (q1_in && cmd_out.op != OP_NONE)
			cmd_out <= '0;
		else if (go_in)
			cmd_out <= req_in;
	end

	// Answers past real memory too, so blanking is the block's job
	assign fetch_out = pc_in[16:1] ^ 16'hC3A5;
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import pcrs_pkg::*;
	logic            clk, rst_n, por_n, cyc, stb, we, go;   // Clock, resets, bus, queue
	logic            ack, q1, cack, sr, srest, sr_seen;     // Design flags
	logic [7:0]      adr;                                   // Bus address
	logic [31:0]     wdat, rdat, q;                         // Bus data, last read
	logic [20:0]     pc_o, pc, t;                           // Seen, expected, target
	logic [15:0]     fetch, instr;                          // Memory and fetched word
	logic [20:0]     stk[$];                                // Expected stack
	pcrs_cmd_type    req, cmd;                              // Queued and live command
	pcrs_shadow_type sh, sh_out, sv;                        // Shadow in, out, expected
	pcrs_op_type     o;                                     // Random operation
	int              errors, checks_done, seed, ticks, i;   // Bookkeeping

	pcrs_top uut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .POR_N_IN(por_n), .CMD_IN(cmd), .SHADOW_IN(sh),
		.FETCH_DATA_IN(fetch), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
		.WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .PC_OUT(pc_o),
		.INSTR_OUT(instr), .FIRST_QUARTER_OUT(q1), .CMD_ACK_OUT(cack), .STACK_RESET_OUT(sr),
		.SHADOW_OUT(sh_out), .SHADOW_RESTORE_OUT(srest));
	pcrs_core_model core (.clk_in(clk), .pc_in(pc_o), .q1_in(q1), .go_in(go), .req_in(req),
		.cmd_out(cmd), .fetch_out(fetch));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Hang guard, runs are well under a thousand cycles
	always @(posedge clk) begin
		ticks++;
		if (ticks > 6000) begin
			errors++;
			complete_run();
		end
	end

	function automatic logic [31:0] fx(input logic [20:0] a);
		return (a >= PROG_BYTES) ? 32'h0 : {16'h0, a[16:1] ^ 16'hC3A5};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, s);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask

	// Classic cycle; held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge clk);
	endtask

	// Model the command, issue it, compare at the ack cycle
	task automatic issue(input pcrs_op_type op, input logic [20:0] tg, input logic f, v);
		pcrs_shadow_type sx;
		sx = pcrs_shadow_type'($random(seed));
		if (op == OP_INT || (op == OP_CALL && f))
			sv = sx;
		case (op)
			OP_STEP: pc = pc + PC_STEP;
			OP_JUMP: pc = tg & ~21'h1;
			OP_RETURN: pc = (stk.size() > 0) ? stk.pop_back() : PC_RESET_VAL;
			OP_POP: void'(stk.pop_back());
			default: begin
				if (stk.size() < 31)
					stk.push_back(pc);
				if (op == OP_CALL)
					pc = tg & ~21'h1;
				if (op == OP_INT)
					pc = v ? VEC_HIGH : VEC_LOW;
			end
		endcase
		sh <= sx;
		req <= '{op: op, fast: f, vec_high: v, target: tg};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do begin
			@(posedge clk);
		end while (cack !== 1'b1);
		sr_seen = sr;
		chk("pc", 32'(pc), 32'(pc_o));
		if (op == OP_INT || (op == OP_CALL && f))
			chk("shadow", 32'(sv), 32'(sh_out));
		if (op == OP_RETURN)
			chk("restore", 32'(f), 32'(srest));
		@(posedge clk);
		chk("fetch", fx(pc), 32'(instr));
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 88603; errors = 0; checks_done = 0; ticks = 0;
		rst_n = 1'b0; por_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; go = 1'b0;
		adr = 8'h00; wdat = 32'h0; req = '0; sh = '0; pc = PC_RESET_VAL;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1; por_n <= 1'b1;
		@(posedge clk);
		chk("pc reset", 32'h0, 32'(pc_o));
		wb(0, OFS_STATUS, 0); chk("status", 32'h0, q);
		wb(0, OFS_CONFIG, 0); chk("option", 32'h1, q);
		wb(0, 8'h40, 0); chk("unmapped", 32'h0, q);
		$display("test reset done");
		for (i = 0; i < 60; i++) begin
			o = pcrs_op_type'(3'({$random(seed)} % 7 + 1));
			if (stk.size() == 0 && (o == OP_RETURN || o == OP_POP)) o = OP_STEP;
			if (stk.size() > 20 && o inside {OP_CALL, OP_INT, OP_PUSH}) o = OP_RETURN;
			issue(o, 21'($random(seed)), 1'($random(seed)), 1'($random(seed)));
		end
		issue(OP_CALL, 21'h0ABCD0, 1'b0, 1'b0);
		wb(0, OFS_STATUS, 0); chk("depth", 32'(stk.size()), q);
		wb(0, OFS_TOP_UP, 0); chk("top upper", 32'(stk[$][20:16]), q);
		wb(1, OFS_TOP_HIGH, 32'h3C); stk[$][15:8] = 8'h3C;
		issue(OP_RETURN, 21'h0, 1'b1, 1'b0);
		$display("test random flow done");
		issue(OP_JUMP, 21'h123456, 1'b0, 1'b0);
		wb(1, OFS_LATH, 32'hA5); wb(0, OFS_PC_LOW, 0); chk("pc low", 32'h56, q);
		wb(0, OFS_LATH, 0); chk("latch copy", 32'h34, q);
		wb(1, OFS_LATU, 32'h0B); wb(1, OFS_PC_LOW, 32'h37);
		wb(0, OFS_PC_FULL, 0); chk("pc load", 32'h0B3436, q);
		pc = 21'h0B3436;
		$display("test latches done");
		wb(1, OFS_STATUS, 0); stk.delete();
		issue(OP_RETURN, 21'h0, 1'b0, 1'b0); chk("underflow req", 32'h1, 32'(sr_seen));
		wb(0, OFS_STATUS, 0); chk("underflow", 32'h40, q);
		wb(1, OFS_STATUS, 32'hC0); wb(0, OFS_STATUS, 0); chk("no set", 32'h40, q);
		wb(1, OFS_STATUS, 0); wb(0, OFS_STATUS, 0); chk("cleared", 32'h0, q);
		wb(1, OFS_CONFIG, 0);
		for (i = 0; i < 32; i++) issue(OP_CALL, 21'(i * 4 + 'h200), 1'b0, 1'b0);
		wb(0, OFS_STATUS, 0); chk("full stop", 32'h9F, q);
		wb(0, OFS_TOP_LOW, 0); chk("kept", 32'(stk[30][7:0]), q);
		wb(1, OFS_STATUS, 0); wb(1, OFS_CONFIG, 1); stk.delete();
		for (i = 0; i < 31; i++) issue(OP_CALL, 21'(i * 4 + 'h400), 1'b0, 1'b0);
		chk("full req", 32'h1, 32'(sr_seen));
		wb(0, OFS_STATUS, 0); chk("full reset", 32'h80, q);
		$display("test stack limits done");
		rst_n <= 1'b0; repeat (3) @(posedge clk); rst_n <= 1'b1; @(posedge clk);
		stk.delete(); pc = PC_RESET_VAL;
		chk("pc rst", 32'h0, 32'(pc_o));
		wb(0, OFS_STATUS, 0); chk("flag kept", 32'h80, q);
		por_n <= 1'b0; repeat (3) @(posedge clk); por_n <= 1'b1; @(posedge clk);
		wb(0, OFS_STATUS, 0); chk("por clear", 32'h0, q);
		$display("test resets done");
		complete_run();
	end
endmodule

bind pcrs_top pcrs_checker chk_i (.CLOCK_IN, .RST_N_IN, .POR_N_IN, .CMD_IN, .SHADOW_IN, .WB_CYC_IN, .PC_OUT,
	.INSTR_OUT, .FIRST_QUARTER_OUT, .STACK_RESET_OUT, .SHADOW_OUT, .SHADOW_RESTORE_OUT);

`default_nettype wire
